// ### adc_scan_pkg.sv
// Package with register map, field layout, reset values and timing for the converter control block.
package adc_scan_pkg;
   localparam int          ADDR_W            = 8;
   localparam int          DATA_W            = 16;
   localparam int          CHANNELS          = 8;
   // Register offsets.
   localparam logic [7:0]  OFF_GENERAL       = 8'h36;
   localparam logic [7:0]  OFF_SCAN_MASK     = 8'h37;
   localparam logic [7:0]  OFF_RANGE_SEL     = 8'h38;
   localparam logic [7:0]  OFF_IRQ_STATUS    = 8'h40;
   localparam logic [7:0]  OFF_IRQ_MASK      = 8'h41;
   // Reset values.
   localparam logic [15:0] RST_GENERAL       = 16'h2000;
   localparam logic [15:0] RST_SCAN_MASK     = 16'h0000;
   localparam logic [15:0] RST_RANGE_SEL     = 16'hff00;
   // Field positions in the general configuration word.
   localparam int          POS_MODE          = 13;
   localparam int          POS_TRIG          = 12;
   localparam int          POS_RATE_LO       = 8;
   localparam int          POS_READY         = 7;
   // Writable bits of the general, scan and range registers.
   localparam logic [15:0] WMASK_GENERAL     = 16'h2300;
   localparam logic [15:0] WMASK_SCAN        = 16'h6de0;
   localparam logic [15:0] WMASK_RANGE       = 16'hff00;
   // Interrupt status bits.
   localparam int          IRQ_DONE          = 0;
   localparam int          IRQ_W             = 1;
   // Base sample period at 500 kSPS; the 250, 125 and 62.5 kSPS codes use two, four and eight times it.
   localparam int          CLK_HZ            = 40_000_000;
   localparam int          SPS_500K          = 500_000;
   localparam int          CYC_500K          = CLK_HZ / SPS_500K;
   localparam int          SCAN_SLOT_CYC     = CYC_500K;
endpackage

// ### adc_slot_timer.sv
// Down counter that times one conversion slot.
`timescale 1ns/1ps
module adc_slot_timer
   import adc_scan_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   input  wire logic             load,
   input  wire logic [CNT_W-1:0] load_value,
   output logic                  expired
);
   logic [CNT_W-1:0] count;

   // The slowest rate needs eight base slots, so the counter must hold that many cycles.
   if (CNT_W < 2 || (SCAN_SLOT_CYC << 3) >= (1 << CNT_W)) begin : g_cnt_w_check
      $error("Slot counter too narrow for the slowest rate.");
   end

   // A load restarts the slot; the counter idles at zero otherwise.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         count <= '0;
      end else if (load) begin
         count <= load_value;
      end else if (count != '0) begin
         count <= count - 1'b1;
      end
   end

   // Pulse on the last cycle of a running slot.
   assign expired = (count == {{(CNT_W-1){1'b0}}, 1'b1});
endmodule

// ### adc_scan_config_regs.sv
// Register file and scan sequencer for the multiplexed converter control block.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module adc_scan_config_regs
   import adc_scan_pkg::*;
(
   input  wire logic                ref_clk,
   input  wire logic                rst_b,
   input  wire logic [ADDR_W-1:0]   reg_addr,
   input  wire logic [DATA_W-1:0]   reg_wdata,
   input  wire logic                reg_write,
   input  wire logic                reg_read,
   output logic      [DATA_W-1:0]   reg_rdata,
   output logic                     irq,
   output logic      [2:0]          analog_input_n,
   output logic                     sample_strobe,
   output logic                     channel_range_bit,
   output logic                     cycle_busy
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SCAN = 2'b01,
      ST_DONE = 2'b10
   } scan_state_t;

   localparam int CNT_W = 16;

   logic [15:0]          general;
   logic [15:0]          channel_scan_enable_bit;
   logic [15:0]          range_sel;
   logic                 ready;
   logic [IRQ_W-1:0]     irq_status;
   logic [IRQ_W-1:0]     irq_mask;
   scan_state_t          state;
   logic [2:0]           chan;
   logic                 slot_load;
   logic [CNT_W-1:0]     slot_len;
   logic                 slot_expired;
   logic [CHANNELS-1:0]  enabled;
   logic                 cycle_end;
   logic                 start_direct;
   logic                 auto_mode;
   logic [15:0]          next_rdata;
   logic [2:0]           next_chan;
   logic                 next_found;
   logic [1:0]           rate_sel;
   logic [2:0]           cur_chan;

   assign auto_mode = general[POS_MODE];

   // Scan bits in channel order; two gaps keep the documented layout.
   // channel bit map
   assign enabled = {channel_scan_enable_bit[5], channel_scan_enable_bit[6],
                     channel_scan_enable_bit[7], channel_scan_enable_bit[8],
                     channel_scan_enable_bit[10], channel_scan_enable_bit[11],
                     channel_scan_enable_bit[13], channel_scan_enable_bit[14]};

   // Slot length doubles per rate step, so 62.5 kSPS is eight base slots.
   // A trigger write that also sets the rate must time its first slot at the new rate.
   // rate to period
   assign rate_sel = (reg_write && reg_addr == OFF_GENERAL) ? reg_wdata[POS_RATE_LO +: 2] :
                                                              general[POS_RATE_LO +: 2];
   assign slot_len = CNT_W'(SCAN_SLOT_CYC << rate_sel);

   // A direct conversion starts when software writes the trigger bit.
   assign start_direct = reg_write && (reg_addr == OFF_GENERAL) &&
                         reg_wdata[POS_TRIG] && !reg_wdata[POS_MODE];

   // Configuration registers; write masks keep reserved bits at zero.
   // general reset
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         general <= RST_GENERAL;
      end else if (reg_write && reg_addr == OFF_GENERAL) begin
         general <= reg_wdata & WMASK_GENERAL;
      end
   end

   // Bits 12 and 9 are expected zero from software and are masked anyway.
   // scan reset
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         channel_scan_enable_bit <= RST_SCAN_MASK;
      end else if (reg_write && reg_addr == OFF_SCAN_MASK) begin
         channel_scan_enable_bit <= reg_wdata & WMASK_SCAN;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         range_sel <= RST_RANGE_SEL;
      end else if (reg_write && reg_addr == OFF_RANGE_SEL) begin
         range_sel <= reg_wdata & WMASK_RANGE;
      end
   end

   // Find next enabled channel after the current one, wrapping; found flags any.
   // skip disabled inputs
   always_comb begin
      logic [2:0] idx;
      next_chan  = chan;
      next_found = 1'b0;
      idx        = chan;
      for (int i = 1; i <= CHANNELS; i++) begin
         idx = 3'(chan + 3'(i));
         if (!next_found && enabled[idx]) begin
            next_chan  = idx;
            next_found = 1'b1;
         end
      end
   end

   // A cycle ends when the slot expires on the highest enabled channel.
   assign cycle_end = slot_expired && (next_chan <= chan);

   // Sequencer walks enabled channels, one slot each.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         state <= ST_IDLE;
         chan  <= 3'd7;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if ((auto_mode || start_direct) && next_found) begin
                  state <= ST_SCAN;
                  chan  <= next_chan;
               end
            end
            ST_SCAN: begin
               if (!next_found) begin
                  state <= ST_IDLE;
                  chan  <= 3'd7;
               end else if (slot_expired) begin
                  chan <= next_chan;
                  if (cycle_end) begin
                     state <= auto_mode ? ST_SCAN : ST_DONE;
                  end
               end
            end
            ST_DONE: begin
               state <= ST_IDLE;
               chan  <= 3'd7;
            end
            default: begin
               state <= ST_IDLE;
               chan  <= 3'd7;
            end
         endcase
      end
   end

   assign slot_load = (state == ST_IDLE && (auto_mode || start_direct) && next_found) ||
                      (state == ST_SCAN && slot_expired && next_found &&
                       !(cycle_end && !auto_mode));

   adc_slot_timer #(
      .CNT_W      (CNT_W)
   ) u_slot_timer (
      .ref_clk    (ref_clk),
      .rst_b      (rst_b),
      .load       (slot_load),
      .load_value (slot_len),
      .expired    (slot_expired)
   );

   // Ready flag: set at the end of a direct cycle, cleared by a new cycle or auto mode.
   // ready set
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         ready <= 1'b0;
      end else if (auto_mode || state == ST_SCAN && !cycle_end) begin
         ready <= 1'b0;
      end else if (state == ST_SCAN && cycle_end) begin
         ready <= 1'b1;
      end else if (slot_load) begin
         ready <= 1'b0;
      end
   end

   // Sticky completion event; set wins over a write-one clear.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         irq_status <= '0;
      end else begin
         irq_status[IRQ_DONE] <= (state == ST_SCAN && cycle_end) ||
            (irq_status[IRQ_DONE] &&
             !(reg_write && reg_addr == OFF_IRQ_STATUS && reg_wdata[IRQ_DONE]));
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         irq_mask <= '0;
      end else if (reg_write && reg_addr == OFF_IRQ_MASK) begin
         irq_mask <= reg_wdata[IRQ_W-1:0];
      end
   end

   assign irq = |(irq_status & irq_mask);

   // Read mux; unmapped addresses return zero.
   // reserved read zero
   always_comb begin
      next_rdata = 16'h0000;
      unique case (reg_addr)
         OFF_GENERAL:    next_rdata = general | (16'(ready) << POS_READY);
         OFF_SCAN_MASK:  next_rdata = channel_scan_enable_bit;
         OFF_RANGE_SEL:  next_rdata = range_sel;
         OFF_IRQ_STATUS: next_rdata = 16'(irq_status);
         OFF_IRQ_MASK:   next_rdata = 16'(irq_mask);
         default:        next_rdata = 16'h0000;
      endcase
   end

   // Read data stands only in the cycle after the strobe.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= reg_read ? next_rdata : 16'h0000;
      end
   end

   // A slot start moves the channel on the same edge, so the outputs follow the new one.
   assign cur_chan = slot_load ? next_chan : chan;

   // Per-channel outputs toward the analog front end.
   // range per channel
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         analog_input_n    <= 3'd0;
         channel_range_bit <= 1'b1;
         sample_strobe     <= 1'b0;
         cycle_busy        <= 1'b0;
      end else begin
         analog_input_n    <= cur_chan;
         channel_range_bit <= range_sel[4'd15 - {1'b0, cur_chan}];
         sample_strobe     <= slot_load;
         cycle_busy        <= (state == ST_SCAN);
      end
   end

   property p_ready_zero_auto;
      @(posedge ref_clk) disable iff (!rst_b)
      $past(auto_mode) |-> !ready;
   endproperty
   a_ready_zero_auto: assert property (p_ready_zero_auto)
      else $error("Ready set in automatic mode.");

   property p_ready_after_cycle;
      @(posedge ref_clk) disable iff (!rst_b)
      (state == ST_SCAN && cycle_end && !auto_mode) |=> ready;
   endproperty
   a_ready_after_cycle: assert property (p_ready_after_cycle)
      else $error("Ready not set after direct cycle.");

   property p_scan_reserved;
      @(posedge ref_clk) disable iff (!rst_b)
      (channel_scan_enable_bit & ~WMASK_SCAN) == 16'h0000;
   endproperty
   a_scan_reserved: assert property (p_scan_reserved)
      else $error("Scan register reserved bit set.");

   property p_general_reserved;
      @(posedge ref_clk) disable iff (!rst_b)
      (general & ~WMASK_GENERAL) == 16'h0000;
   endproperty
   a_general_reserved: assert property (p_general_reserved)
      else $error("General register reserved bit set.");

   property p_range_reserved;
      @(posedge ref_clk) disable iff (!rst_b)
      (range_sel & ~WMASK_RANGE) == 16'h0000;
   endproperty
   a_range_reserved: assert property (p_range_reserved)
      else $error("Range register reserved bit set.");

   property p_ready_clear_start;
      @(posedge ref_clk) disable iff (!rst_b)
      (state == ST_IDLE && slot_load) |=> !ready;
   endproperty
   a_ready_clear_start: assert property (p_ready_clear_start)
      else $error("Ready still set after a new cycle started.");

   property p_chan_enabled;
      @(posedge ref_clk) disable iff (!rst_b)
      (state == ST_SCAN && next_found) |-> enabled[chan];
   endproperty
   a_chan_enabled: assert property (p_chan_enabled)
      else $error("Disabled channel converted.");

   property p_ready_readonly;
      @(posedge ref_clk) disable iff (!rst_b)
      (reg_write && reg_addr == OFF_GENERAL && state == ST_IDLE && !slot_load && !ready)
         |=> !ready;
   endproperty
   a_ready_readonly: assert property (p_ready_readonly)
      else $error("Write changed ready flag.");

   property p_range_reset;
      @(posedge ref_clk) $rose(rst_b) |-> range_sel == RST_RANGE_SEL;
   endproperty
   a_range_reset: assert property (p_range_reset)
      else $error("Range register wrong after reset.");

   property p_general_reset;
      @(posedge ref_clk) $rose(rst_b) |-> general == RST_GENERAL;
   endproperty
   a_general_reset: assert property (p_general_reset)
      else $error("General register wrong after reset.");

   property p_scan_reset;
      @(posedge ref_clk) $rose(rst_b) |-> channel_scan_enable_bit == RST_SCAN_MASK;
   endproperty
   a_scan_reset: assert property (p_scan_reset)
      else $error("Scan register wrong after reset.");

   c_direct_done: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(ready));
   c_irq: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(irq));
   c_auto_scan: cover property (@(posedge ref_clk) disable iff (!rst_b)
      auto_mode && state == ST_SCAN && cycle_end);
   c_single_span: cover property (@(posedge ref_clk) disable iff (!rst_b)
      sample_strobe && !channel_range_bit);
endmodule

// ### adc_scan_config_regs_tb_top.sv
// Self-checking testbench for the converter control register block.
`timescale 1ns/1ps
module adc_scan_config_regs_tb_top;
   import adc_scan_pkg::*;
   typedef struct {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic [15:0] exp_rd;
   } row_t;
   logic              ref_clk;
   logic              rst_b;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic              reg_write;
   logic              reg_read;
   logic [DATA_W-1:0] reg_rdata;
   logic              irq;
   logic [2:0]        analog_input_n;
   logic              sample_strobe;
   logic              channel_range_bit;
   logic              cycle_busy;
   int                num_errors;
   int                comparisons;
   int                nstb;
   int                last;
   row_t              rows [8];

   adc_scan_config_regs DUT (
      .ref_clk           (ref_clk),
      .rst_b             (rst_b),
      .reg_addr          (reg_addr),
      .reg_wdata         (reg_wdata),
      .reg_write         (reg_write),
      .reg_read          (reg_read),
      .reg_rdata         (reg_rdata),
      .irq               (irq),
      .analog_input_n    (analog_input_n),
      .sample_strobe     (sample_strobe),
      .channel_range_bit (channel_range_bit),
      .cycle_busy        (cycle_busy)
   );

   // Free-running 40 MHz clock.
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Writes end one idle cycle later so a strobe is never set twice in one step.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
      @(posedge ref_clk);
   endtask

   // Read data stands only in the cycle after the strobe, so it is sampled mid-cycle.
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      @(negedge ref_clk);
      chk16(reg_rdata, e);
      @(posedge ref_clk);
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Watchdog well beyond the fewer than a thousand cycles the tests need.
   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      tally_and_finish();
   end

   initial begin
      rst_b = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_write = 1'b0;
      reg_read = 1'b0;
      num_errors = 0;
      comparisons = 0;
      rows = '{'{8'h36, 16'hefff, 16'h2300}, '{8'h37, 16'hedff, 16'h6de0},
               '{8'h38, 16'h00ff, 16'h0000}, '{8'h38, 16'ha5ff, 16'ha500},
               '{8'h50, 16'hffff, 16'h0000}, '{8'h37, 16'h0000, 16'h0000},
               '{8'h36, 16'h0000, 16'h0000}, '{8'h41, 16'h0001, 16'h0001}};
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      // Ordinary write and read-back cases, reserved and unmapped places among them.
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdata);
         rd_chk(rows[i].addr, rows[i].exp_rd);
      end
      $display("test register rows done");
      // Direct cycle over inputs 0 and 7 at the 250 kSPS rate; the sequencer may still
      // be finishing the automatic scan, so let it settle first.
      for (int n = 0; n < 2000 && cycle_busy !== 1'b0; n++) @(posedge ref_clk);
      wr(8'h40, 16'h0001);
      wr(8'h37, 16'h4020);
      wr(8'h38, 16'h0100);
      reg_addr <= 8'h36;
      reg_wdata <= 16'h1100;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
      nstb = 0;
      last = 0;
      for (int n = 1; n < 1000; n++) begin
         @(negedge ref_clk);
         if (n == 4) chk1(cycle_busy, 1'b1);
         if (sample_strobe === 1'b1) begin
            chk16({13'h0000, analog_input_n}, (nstb == 0) ? 16'h0000 : 16'h0007);
            chk1(channel_range_bit, nstb != 0);
            if (nstb == 1) chk16(16'(n - last), 16'h00a0);
            last = n;
            nstb++;
         end
         if (n > 4 && cycle_busy === 1'b0) break;
      end
      chk16(16'(nstb), 16'h0002);
      @(posedge ref_clk);
      rd_chk(8'h36, 16'h0180);
      chk1(irq, 1'b1);
      rd_chk(8'h40, 16'h0001);
      wr(8'h41, 16'h0000);
      chk1(irq, 1'b0);
      wr(8'h40, 16'h0001);
      wr(8'h41, 16'h0001);
      chk1(irq, 1'b0);
      rd_chk(8'h40, 16'h0000);
      $display("test direct cycle done");
      // Automatic mode clears the flag and keeps it clear across a finished cycle.
      wr(8'h36, 16'h2100);
      rd_chk(8'h36, 16'h2100);
      for (int n = 0; n < 2000 && irq !== 1'b1; n++) @(negedge ref_clk);
      chk1(irq, 1'b1);
      @(posedge ref_clk);
      rd_chk(8'h36, 16'h2100);
      $display("test automatic mode done");
      // A second reset in mid-scan restores registers 36, 37, 38 and 40 and the irq, busy and range outputs.
      rst_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(negedge ref_clk);
      chk1(irq, 1'b0);
      chk1(cycle_busy, 1'b0);
      chk1(channel_range_bit, 1'b1);
      @(posedge ref_clk);
      rd_chk(8'h36, 16'h2000);
      rd_chk(8'h37, 16'h0000);
      rd_chk(8'h38, 16'hff00);
      rd_chk(8'h40, 16'h0000);
      $display("test reset values done");
      tally_and_finish();
   end
endmodule
